// *** rtl/pwm_pkg.sv ***
// Constants, register map and carrier types of the flyback PWM sequencer.
// Assumes a 10 MHz core clock; all cycle counts below derive from it.
package pwm_pkg;

    // Clock and timing.
    localparam int CLK_HZ = 10_000_000;
    localparam int CLK_NS = 1_000_000_000 / CLK_HZ;
    localparam int T_ON_MIN_NS = 300;
    localparam int ON_MIN_CYC = (T_ON_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int SS_TIME_MS = 8;
    localparam int SS_STEPS = 8;
    localparam int SS_CYC = SS_TIME_MS * (CLK_HZ / 1000);
    localparam int RESTART_TIME_MS = 1000;
    localparam int RESTART_CYC = RESTART_TIME_MS * (CLK_HZ / 1000);
    localparam int FM_HZ = 260;
    localparam int FM_CYC = CLK_HZ / FM_HZ;
    localparam int JIT_PCT = 7;
    localparam int DMAX_PCT = 75;

    // Switching frequency options.
    localparam int FOSC_X_KHZ = 30;
    localparam int FOSC_L_KHZ = 60;
    localparam int FOSC_H_KHZ = 120;
    localparam int FOSC_MIN_KHZ = 15;
    localparam int PER_X = CLK_HZ / (FOSC_X_KHZ * 1000);
    localparam int PER_L = CLK_HZ / (FOSC_L_KHZ * 1000);
    localparam int PER_H = CLK_HZ / (FOSC_H_KHZ * 1000);
    localparam int PER_MIN = CLK_HZ / (FOSC_MIN_KHZ * 1000);
    localparam int DEV_X = PER_X * JIT_PCT / 100;
    localparam int DEV_L = PER_L * JIT_PCT / 100;
    localparam int DEV_H = PER_H * JIT_PCT / 100;
    localparam logic [1:0] FSEL_X = 2'h0;
    localparam logic [1:0] FSEL_L = 2'h1;

    // Register map, byte offsets.
    localparam int ADDR_W = 4;
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_IRQ_STATUS = 4'h8;
    localparam logic [3:0] REG_IRQ_MASK = 4'hc;
    localparam logic [1:0] CTRL_FSEL_RESET = 2'h1;
    localparam int CTRL_FSEL_LSB = 0;
    localparam int STAT_PHASE_LSB = 0;
    localparam int STAT_LOCKOUT_BIT = 2;
    localparam int STAT_GATE_BIT = 3;
    localparam int STAT_STEP_LSB = 4;
    localparam int STAT_SKIP_LSB = 8;
    localparam int STAT_CHG_BIT = 11;
    localparam int STAT_CHGHI_BIT = 12;
    localparam int IRQ_W = 4;
    localparam int IRQ_FAULT = 0;
    localparam int IRQ_SKIP = 1;
    localparam int IRQ_SS_DONE = 2;
    localparam int IRQ_LOCKOUT = 3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        ST_LOCKOUT = 2'h0,
        ST_SOFT = 2'h1,
        ST_RUN = 2'h3,
        ST_WAIT = 2'h2
    } phase_t;

    // Analog comparator results, one bit each.
    typedef struct packed {
        logic drain_above_start;
        logic supply_above_1v;
        logic supply_above_on;
        logic supply_above_off;
        logic supply_above_reenable;
        logic peak_current_limit;
        logic fault_trip;
    } cmp_t;

    function automatic logic [8:0] period_nom(input logic [1:0] fsel);
        case (fsel)
            FSEL_X: period_nom = 9'(PER_X);
            FSEL_L: period_nom = 9'(PER_L);
            default: period_nom = 9'(PER_H);
        endcase
    endfunction : period_nom

    function automatic logic [4:0] jit_dev(input logic [1:0] fsel);
        case (fsel)
            FSEL_X: jit_dev = 5'(DEV_X);
            FSEL_L: jit_dev = 5'(DEV_L);
            default: jit_dev = 5'(DEV_H);
        endcase
    endfunction : jit_dev

    function automatic logic [2:0] skip_max(input logic [1:0] fsel);
        case (fsel)
            FSEL_X: skip_max = 3'(PER_MIN / PER_X - 1);
            FSEL_L: skip_max = 3'(PER_MIN / PER_L - 1);
            default: skip_max = 3'(PER_MIN / PER_H - 1);
        endcase
    endfunction : skip_max

endpackage : pwm_pkg

// *** rtl/cmp_sync.sv ***
// Two-stage synchroniser for the analog comparator outputs.
// Assumes the comparator levels may change at any time relative to aclk.
module cmp_sync (
    // Clock
    input wire logic aclk,
    // Raw and synchronised comparator levels
    input wire pwm_pkg::cmp_t raw,
    output pwm_pkg::cmp_t synced
);
    typedef struct packed {
        pwm_pkg::cmp_t first;
        pwm_pkg::cmp_t second;
    } sync_t;

    sync_t s;
    sync_t next_s;

    // No reset: the chain flushes within two edges and resetting it buys nothing.
    always_comb begin
        next_s.first = raw;
        next_s.second = s.first;
    end

    always_ff @(posedge aclk) begin
        s <= next_s;
    end

    assign synced = s.second;
endmodule : cmp_sync

// *** rtl/flyback_pwm_sequencer.sv ***
// Digital control core of a current-mode flyback converter with AXI4-Lite registers.
// Assumes comparator inputs from the analog stage and a single 10 MHz clock.
//
// Added by the designer: register access over AXI4-Lite and the register addresses.
module flyback_pwm_sequencer #(
    parameter int SS_CYC_P = pwm_pkg::SS_CYC,
    parameter int RESTART_CYC_P = pwm_pkg::RESTART_CYC,
    parameter int FM_CYC_P = pwm_pkg::FM_CYC
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Analog comparators
    input wire pwm_pkg::cmp_t cmp,
    // Power stage controls
    output logic gate_on,
    output logic hv_source_en,
    output logic charge_current_high,
    output logic [3:0] limit_step,
    output logic undervoltage_lockout,
    // AXI4-Lite write channels
    input wire logic awvalid,
    output logic awready,
    input wire logic [pwm_pkg::ADDR_W-1:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read channels
    input wire logic arvalid,
    output logic arready,
    input wire logic [pwm_pkg::ADDR_W-1:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // Interrupt
    output logic irq
);
    localparam logic [23:0] SS_STEP_LAST = 24'(SS_CYC_P / pwm_pkg::SS_STEPS - 1);
    localparam logic [23:0] RESTART_LAST = 24'(RESTART_CYC_P - 1);
    localparam logic [3:0] STEP_FULL = 4'(pwm_pkg::SS_STEPS);
    localparam logic [2:0] ON_MIN = 3'(pwm_pkg::ON_MIN_CYC);
    localparam int JIT_STEP_X = FM_CYC_P / (4 * pwm_pkg::DEV_X);
    localparam int JIT_STEP_L = FM_CYC_P / (4 * pwm_pkg::DEV_L);
    localparam int JIT_STEP_H = FM_CYC_P / (4 * pwm_pkg::DEV_H);

    typedef struct packed {
        pwm_pkg::phase_t phase;
        logic lockout;
        logic gate;
        logic charging;
        logic chg_high;
        logic [3:0] step;
        logic [23:0] tmr;
        logic [8:0] cyc;
        logic [2:0] on_cnt;
        logic early;
        logic [2:0] skip_lvl;
        logic [2:0] skip_cnt;
        logic signed [5:0] jit;
        logic jit_up;
        logic [15:0] jit_tmr;
        logic [1:0] fsel;
        logic [pwm_pkg::IRQ_W-1:0] ist;
        logic [pwm_pkg::IRQ_W-1:0] imask;
        logic irq;
        logic aw_ok;
        logic [pwm_pkg::ADDR_W-1:0] aw_addr;
        logic w_ok;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } state_t;

    state_t s;
    state_t next_s;
    pwm_pkg::cmp_t c;

    // Jitter slope: one period step per interval gives a full triangle at the modulation rate.
    function automatic logic [15:0] jit_interval(input logic [1:0] fsel);
        case (fsel)
            pwm_pkg::FSEL_X: jit_interval = 16'(JIT_STEP_X - 1);
            pwm_pkg::FSEL_L: jit_interval = 16'(JIT_STEP_L - 1);
            default: jit_interval = 16'(JIT_STEP_H - 1);
        endcase
    endfunction : jit_interval

    cmp_sync u_sync (
        .aclk(aclk),
        .raw(cmp),
        .synced(c)
    );

    logic [9:0] per_sum;
    logic [8:0] per;
    logic [15:0] duty_prod;
    logic wrap;
    logic running;
    logic signed [5:0] dev;
    logic wr;
    logic [pwm_pkg::IRQ_W-1:0] clr;
    logic [pwm_pkg::IRQ_W-1:0] ev;
    logic [31:0] rd;

    always_comb begin
        next_s = s;
        clr = '0;
        ev = '0;
        rd = '0;
        dev = $signed({1'b0, pwm_pkg::jit_dev(s.fsel)});
        per_sum = 10'($signed({1'b0, pwm_pkg::period_nom(s.fsel)}) + s.jit);
        per = per_sum[8:0];
        duty_prod = 16'(per * 7'(pwm_pkg::DMAX_PCT));
        wrap = s.cyc >= per - 9'h1;
        running = (s.phase == pwm_pkg::ST_SOFT) || (s.phase == pwm_pkg::ST_RUN);
        wr = s.aw_ok && s.w_ok && !s.bvalid;

        // Write address and data are taken independently, in either order.
        if (s.awready && awvalid) begin
            next_s.aw_ok = 1'b1;
            next_s.aw_addr = awaddr;
        end
        if (s.wready && wvalid) begin
            next_s.w_ok = 1'b1;
            next_s.wdata = wdata;
            next_s.wstrb = wstrb;
        end
        if (s.bvalid && bready) begin
            next_s.bvalid = 1'b0;
        end
        if (wr) begin
            next_s.aw_ok = 1'b0;
            next_s.w_ok = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = pwm_pkg::RESP_OKAY;
            case (s.aw_addr)
                pwm_pkg::REG_CTRL: begin
                    if (s.wstrb[0]) begin
                        next_s.fsel = s.wdata[pwm_pkg::CTRL_FSEL_LSB +: 2];
                    end
                end
                pwm_pkg::REG_STATUS: begin
                end
                pwm_pkg::REG_IRQ_STATUS: begin
                    if (s.wstrb[0]) begin
                        clr = s.wdata[pwm_pkg::IRQ_W-1:0];
                    end
                end
                pwm_pkg::REG_IRQ_MASK: begin
                    if (s.wstrb[0]) begin
                        next_s.imask = s.wdata[pwm_pkg::IRQ_W-1:0];
                    end
                end
                default: begin
                    next_s.bresp = pwm_pkg::RESP_SLVERR;
                end
            endcase
        end
        next_s.awready = !next_s.aw_ok && !next_s.bvalid;
        next_s.wready = !next_s.w_ok && !next_s.bvalid;

        // Read: one outstanding, data captured when the address is taken.
        rd[pwm_pkg::STAT_PHASE_LSB +: 2] = s.phase;
        rd[pwm_pkg::STAT_LOCKOUT_BIT] = s.lockout;
        rd[pwm_pkg::STAT_GATE_BIT] = s.gate;
        rd[pwm_pkg::STAT_STEP_LSB +: 4] = s.step;
        rd[pwm_pkg::STAT_SKIP_LSB +: 3] = s.skip_lvl;
        rd[pwm_pkg::STAT_CHG_BIT] = s.charging;
        rd[pwm_pkg::STAT_CHGHI_BIT] = s.chg_high;
        if (s.arready && arvalid) begin
            next_s.arready = 1'b0;
            next_s.rvalid = 1'b1;
            next_s.rresp = pwm_pkg::RESP_OKAY;
            case (araddr)
                pwm_pkg::REG_CTRL: next_s.rdata = 32'(s.fsel);
                pwm_pkg::REG_STATUS: next_s.rdata = rd;
                pwm_pkg::REG_IRQ_STATUS: next_s.rdata = 32'(s.ist);
                pwm_pkg::REG_IRQ_MASK: next_s.rdata = 32'(s.imask);
                default: begin
                    next_s.rdata = '0;
                    next_s.rresp = pwm_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (s.rvalid && rready) begin
            next_s.rvalid = 1'b0;
            next_s.arready = 1'b1;
        end

        // Triangle jitter of the period between -dev and +dev.
        next_s.jit_tmr = s.jit_tmr + 16'h1;
        if (s.jit_tmr >= jit_interval(s.fsel)) begin
            next_s.jit_tmr = '0;
            if (s.jit_up) begin
                if (s.jit >= dev) begin
                    next_s.jit_up = 1'b0;
                    next_s.jit = s.jit - 6'sh1;
                end else begin
                    next_s.jit = s.jit + 6'sh1;
                end
            end else begin
                if (s.jit <= -dev) begin
                    next_s.jit_up = 1'b1;
                    next_s.jit = s.jit + 6'sh1;
                end else begin
                    next_s.jit = s.jit - 6'sh1;
                end
            end
        end

        // Oscillator and gate.
        next_s.cyc = wrap ? 9'h0 : s.cyc + 9'h1;
        if (s.gate) begin
            if (s.on_cnt != 3'h7) begin
                next_s.on_cnt = s.on_cnt + 3'h1;
            end
            if (c.peak_current_limit && s.on_cnt < ON_MIN) begin
                next_s.early = 1'b1;
            end
            // Turn-off waits for the minimum on-time even if the limit tripped earlier.
            if ((c.peak_current_limit || {7'h0, s.cyc} >= duty_prod / 16'd100) && s.on_cnt >= ON_MIN) begin
                next_s.gate = 1'b0;
                next_s.early = 1'b0;
                if (s.early) begin
                    if (s.skip_lvl < pwm_pkg::skip_max(s.fsel)) begin
                        next_s.skip_lvl = s.skip_lvl + 3'h1;
                        ev[pwm_pkg::IRQ_SKIP] = 1'b1;
                    end
                end else if (s.skip_lvl != 3'h0) begin
                    next_s.skip_lvl = s.skip_lvl - 3'h1;
                end
            end
        end else if (wrap && running) begin
            if (s.skip_cnt == 3'h0) begin
                next_s.gate = 1'b1;
                next_s.on_cnt = 3'h1;
                next_s.skip_cnt = s.skip_lvl;
            end else begin
                next_s.skip_cnt = s.skip_cnt - 3'h1;
            end
        end

        // Start-up, soft-start and restart sequencing.
        next_s.tmr = s.tmr + 24'h1;
        case (s.phase)
            pwm_pkg::ST_LOCKOUT: begin
                next_s.tmr = '0;
                if (c.supply_above_on) begin
                    next_s.phase = pwm_pkg::ST_SOFT;
                    next_s.lockout = 1'b0;
                    next_s.step = '0;
                end
            end
            pwm_pkg::ST_SOFT: begin
                if (s.tmr == SS_STEP_LAST) begin
                    next_s.tmr = '0;
                    next_s.step = s.step + 4'h1;
                    if (s.step == STEP_FULL - 4'h1) begin
                        next_s.phase = pwm_pkg::ST_RUN;
                        ev[pwm_pkg::IRQ_SS_DONE] = 1'b1;
                    end
                end
            end
            pwm_pkg::ST_RUN: begin
                next_s.tmr = '0;
            end
            pwm_pkg::ST_WAIT: begin
                if (s.tmr == RESTART_LAST) begin
                    next_s.tmr = '0;
                    next_s.step = '0;
                    next_s.phase = pwm_pkg::ST_SOFT;
                end
            end
            default: begin
                next_s.phase = pwm_pkg::ST_LOCKOUT;
            end
        endcase
        if (running && c.fault_trip) begin
            next_s.phase = pwm_pkg::ST_WAIT;
            next_s.tmr = '0;
            next_s.step = '0;
            ev[pwm_pkg::IRQ_FAULT] = 1'b1;
        end
        if (s.phase != pwm_pkg::ST_LOCKOUT && !c.supply_above_off) begin
            next_s.phase = pwm_pkg::ST_LOCKOUT;
            next_s.lockout = 1'b1;
            next_s.step = '0;
            ev[pwm_pkg::IRQ_LOCKOUT] = 1'b1;
        end
        if (next_s.phase == pwm_pkg::ST_LOCKOUT || next_s.phase == pwm_pkg::ST_WAIT) begin
            next_s.gate = 1'b0;
            next_s.skip_lvl = '0;
            next_s.skip_cnt = '0;
            next_s.early = 1'b0;
        end

        // Charger is hysteretic: on below the re-enable level, off at the turn-on level.
        if (!(next_s.phase == pwm_pkg::ST_LOCKOUT || next_s.phase == pwm_pkg::ST_WAIT)
                || c.supply_above_on || !c.drain_above_start) begin
            next_s.charging = 1'b0;
        end else if (!c.supply_above_reenable) begin
            next_s.charging = 1'b1;
        end
        next_s.chg_high = next_s.charging && c.supply_above_1v;

        // A new event wins over a clear in the same cycle.
        next_s.ist = (s.ist & ~clr) | ev;
        next_s.irq = |(next_s.ist & next_s.imask);

        if (!aresetn) begin
            next_s = '0;
            next_s.phase = pwm_pkg::ST_LOCKOUT;
            next_s.lockout = 1'b1;
            next_s.fsel = pwm_pkg::CTRL_FSEL_RESET;
            next_s.jit_up = 1'b1;
            next_s.awready = 1'b1;
            next_s.wready = 1'b1;
            next_s.arready = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        s <= next_s;
    end

    assign gate_on = s.gate;
    assign hv_source_en = s.charging;
    assign charge_current_high = s.chg_high;
    assign limit_step = s.step;
    assign undervoltage_lockout = s.lockout;
    assign awready = s.awready;
    assign wready = s.wready;
    assign bvalid = s.bvalid;
    assign bresp = s.bresp;
    assign arready = s.arready;
    assign rvalid = s.rvalid;
    assign rdata = s.rdata;
    assign rresp = s.rresp;
    assign irq = s.irq;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_step_bound: assert property (limit_step <= STEP_FULL)
        else $error("soft-start step above full limit");
    a_step_pace: assert property ((s.phase == pwm_pkg::ST_SOFT) && $changed(limit_step)
            && limit_step != 4'h0 |-> $past(s.tmr) == SS_STEP_LAST)
        else $error("soft-start step advanced off schedule");
    a_ss_entry: assert property ($changed(s.phase) && s.phase == pwm_pkg::ST_SOFT |-> limit_step == 4'h0)
        else $error("soft-start entered without zero limit");
    a_restart_to_soft: assert property ($past(s.phase) == pwm_pkg::ST_WAIT
            && s.phase == pwm_pkg::ST_RUN |-> 1'b0)
        else $error("restart skipped soft-start");
    a_skip_cap: assert property (s.skip_lvl <= pwm_pkg::skip_max(s.fsel))
        else $error("skip level beyond minimum frequency");
    a_skip_up: assert property (s.gate && !next_s.gate && s.early && running && !c.fault_trip
            && c.supply_above_off && s.skip_lvl < pwm_pkg::skip_max(s.fsel) |=> s.skip_lvl == $past(s.skip_lvl) + 3'h1)
        else $error("early trip did not add a skipped cycle");
    a_min_on: assert property ($fell(gate_on) && s.phase != pwm_pkg::ST_LOCKOUT
            && s.phase != pwm_pkg::ST_WAIT |-> $past(s.on_cnt) >= ON_MIN)
        else $error("gate released before minimum on-time");
    a_wait_no_gate: assert property (s.phase == pwm_pkg::ST_WAIT |-> !gate_on)
        else $error("gate active during restart delay");
    a_lockout_gate: assert property (undervoltage_lockout |-> !gate_on)
        else $error("gate active during undervoltage lockout");
    a_run_no_charge: assert property (s.phase == pwm_pkg::ST_RUN |-> !hv_source_en)
        else $error("charger on while switching");
    a_reenable_off: assert property (!hv_source_en && c.supply_above_reenable |=> !hv_source_en)
        else $error("charger enabled above re-enable level");
    a_low_current: assert property (charge_current_high |-> hv_source_en && $past(c.supply_above_1v))
        else $error("high charge current below one volt");
    a_drain_low: assert property (!c.drain_above_start |=> !hv_source_en)
        else $error("charger on with low drain voltage");
    a_charge_start: assert property (s.phase == pwm_pkg::ST_LOCKOUT && c.drain_above_start
            && !c.supply_above_on && !c.supply_above_reenable && c.supply_above_off |=> hv_source_en)
        else $error("charger not enabled on drain start level");
endmodule : flyback_pwm_sequencer

// *** test/power_stage_model.sv ***
// Analog power stage model: supply and drain comparators plus a drain current ramp.
// Assumes the bench sets supply level, drain state, fault and the trip point.
module power_stage_model (
    // Clock and gate
    input wire logic aclk,
    input wire logic gate_on,
    // Bench stimulus
    input wire logic [2:0] supply_lvl,
    input wire logic drain_hi,
    input wire logic fault,
    input wire logic [7:0] trip_at,
    // Comparator levels
    output pwm_pkg::cmp_t cmp
);
    logic [7:0] on_cnt = 8'h00;
    initial cmp = '0;
    // A trip point of zero stands for runaway current already at the limit when the switch turns on.
    // The synchroniser delay would otherwise hide any trip inside the minimum on-time.
    always @(posedge aclk) begin
        on_cnt <= gate_on ? on_cnt + 8'h01 : 8'h00;
        cmp <= {drain_hi, supply_lvl >= 3'h1, supply_lvl >= 3'h4, supply_lvl >= 3'h2,
                supply_lvl >= 3'h3, trip_at == 8'h00 || (gate_on && on_cnt >= trip_at), fault};
    end
endmodule : power_stage_model

// *** test/tb.sv ***
// Self-checking bench of the PWM sequencer with shortened soft-start and restart counts.
// Assumes the stage model drives the comparators; registers go over AXI4-Lite.
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int SS = 800;
    localparam int RS = 500;
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_count++; \
    $display("Error %0t got %0h exp %0h", $time, g, e); end end
`define WAITC(c, n) for (wt = 0; wt < (n) && !(c); wt++) @(posedge aclk);
    logic aclk = 1'b0, aresetn = 1'b0, drain_hi = 1'b0, fault = 1'b0;
    logic [2:0] supply_lvl = 3'h0;
    logic [7:0] trip_at = 8'h14;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0, limit_step;
    logic [31:0] wdata = 32'h0, rd, rdata;
    logic [1:0] bresp, rresp;
    logic awready, wready, bvalid, arready, rvalid, gate_on, hv_source_en, charge_current_high;
    logic undervoltage_lockout, irq;
    pwm_pkg::cmp_t cmp;
    int err_count = 0, n_tests = 0, wt, cyc = 0, hi, per, mn, mx, nom, dev;
    flyback_pwm_sequencer #(.SS_CYC_P(SS), .RESTART_CYC_P(RS), .FM_CYC_P(2000)) u_dut (
        .aclk(aclk), .aresetn(aresetn), .cmp(cmp), .gate_on(gate_on), .hv_source_en(hv_source_en),
        .charge_current_high(charge_current_high), .limit_step(limit_step),
        .undervoltage_lockout(undervoltage_lockout), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hf),
        .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
        .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .irq(irq));
    power_stage_model u_stage (.aclk(aclk), .gate_on(gate_on), .supply_lvl(supply_lvl),
        .drain_hi(drain_hi), .fault(fault), .trip_at(trip_at), .cmp(cmp));
    initial forever #50 aclk = ~aclk;
    task wrap_up;
        if (err_count == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : wrap_up
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            err_count++;
            wrap_up();
        end
    end
    task axw(input logic [3:0] a, input logic [31:0] d);
        @(posedge aclk);
        {awvalid, wvalid, bready} <= 3'b111;
        awaddr <= a;
        wdata <= d;
        do begin
            @(posedge aclk);
            awvalid <= awvalid && !awready;
            wvalid <= wvalid && !wready;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        `CHK(bresp, pwm_pkg::RESP_OKAY)
    endtask : axw
    task axr(input logic [3:0] a);
        @(posedge aclk);
        {arvalid, rready} <= 2'b11;
        araddr <= a;
        do begin
            @(posedge aclk);
            arvalid <= arvalid && !arready;
        end while (rvalid !== 1'b1);
        rd = rdata;
        rready <= 1'b0;
        `CHK(rresp, pwm_pkg::RESP_OKAY)
    endtask : axr
    // Returns at a gate rise with the high time and the rise-to-rise period of the pulse before it.
    task gate_cycle;
        `WAITC(gate_on === 1'b0, 4000)
        `WAITC(gate_on === 1'b1, 4000)
        for (per = 0; gate_on === 1'b1 && per < 4000; per++) @(posedge aclk);
        hi = per;
        for (; gate_on !== 1'b1 && per < 4000; per++) @(posedge aclk);
    endtask : gate_cycle
    task t_start;
        `CHK({undervoltage_lockout, gate_on, hv_source_en}, 3'b100)
        {drain_hi, supply_lvl} <= 4'hb;
        repeat (5) @(posedge aclk);
        `CHK(hv_source_en, 1'b0)
        supply_lvl <= 3'h0;
        repeat (5) @(posedge aclk);
        `CHK({hv_source_en, charge_current_high}, 2'b10)
        supply_lvl <= 3'h2;
        repeat (5) @(posedge aclk);
        `CHK(charge_current_high, 1'b1)
        supply_lvl <= 3'h4;
        repeat (5) @(posedge aclk);
        `CHK({hv_source_en, undervoltage_lockout}, 2'b00)
        `WAITC(limit_step === 4'h1, SS)
        `WAITC(limit_step === 4'h2, SS)
        `CHK(wt, SS / 8)
        `WAITC(limit_step === 4'h8, SS)
        `CHK(limit_step, 4'h8)
    endtask : t_start
    task t_freq;
        for (int f = 0; f < 3; f++) begin
            axw(pwm_pkg::REG_CTRL, 32'(f));
            nom = f == 0 ? pwm_pkg::PER_X : f == 1 ? pwm_pkg::PER_L : pwm_pkg::PER_H;
            dev = f == 0 ? pwm_pkg::DEV_X : f == 1 ? pwm_pkg::DEV_L : pwm_pkg::DEV_H;
            // The jitter offset carries over from the old setting and needs time to walk into range.
            repeat (800) @(posedge aclk);
            gate_cycle();
            mn = 9999;
            mx = 0;
            repeat (24) begin
                gate_cycle();
                mn = per < mn ? per : mn;
                mx = per > mx ? per : mx;
            end
            `CHK(mn >= nom - dev - 2 && mx <= nom + dev + 2, 1'b1)
            `CHK(mx - mn >= dev, 1'b1)
        end
        axw(pwm_pkg::REG_CTRL, 32'h1);
    endtask : t_freq
    task t_skip;
        axw(pwm_pkg::REG_IRQ_MASK, 32'h2);
        trip_at <= 8'h00;
        repeat (12) begin
            gate_cycle();
            `CHK(hi >= 3, 1'b1)
        end
        nom = pwm_pkg::PER_L;
        dev = pwm_pkg::DEV_L;
        `CHK(per >= 4 * (nom - dev - 2) && per <= 4 * (nom + dev + 2), 1'b1)
        `CHK(irq, 1'b1)
        axr(pwm_pkg::REG_STATUS);
        `CHK(rd[10:8], 3'(pwm_pkg::PER_MIN / nom - 1))
        trip_at <= 8'h14;
        repeat (6) gate_cycle();
        `CHK(per <= nom + dev + 2, 1'b1)
        axr(pwm_pkg::REG_STATUS);
        `CHK(rd[10:8], 3'h0)
        axw(pwm_pkg::REG_IRQ_STATUS, 32'hf);
        repeat (3) @(posedge aclk);
        `CHK(irq, 1'b0)
    endtask : t_skip
    task t_fault;
        fault <= 1'b1;
        `WAITC(gate_on === 1'b0 && limit_step === 4'h0, 50)
        fault <= 1'b0;
        `WAITC(gate_on === 1'b1, RS + 400)
        `CHK(wt >= RS - 5 && wt <= RS + pwm_pkg::PER_L + 30, 1'b1)
        `CHK(limit_step < 4'h8, 1'b1)
        `WAITC(limit_step === 4'h8, SS + 50)
        `CHK(limit_step, 4'h8)
    endtask : t_fault
    task t_lockout;
        {drain_hi, supply_lvl} <= 4'h1;
        `WAITC(undervoltage_lockout === 1'b1, 20)
        `CHK(gate_on, 1'b0)
        `WAITC(gate_on === 1'b1, 400)
        `CHK({gate_on, hv_source_en, undervoltage_lockout}, 3'b001)
    endtask : t_lockout
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        t_start();
        t_freq();
        t_skip();
        t_fault();
        t_lockout();
        wrap_up();
    end
endmodule : tb
